// ---- bench/dac_ctrl_checker.sv ----
module dac_ctrl_checker (
  input wire logic                                    core_clk_in,
  input wire logic                                    srst_in,
  input wire logic                                    psel_in,
  input wire logic                                    penable_in,
  input wire logic                                    pready_out,
  input wire logic [dac_ctrl_pkg::MV_BITS-1:0]        vdd_mv_in,
  input wire dac_ctrl_pkg::chan_out_t [1:0]           chan_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  dac_ctrl_pkg::chan_out_t c;
  assign c = chan_out[0];
  src_onehot_a: assert property (
    c.ladder_connect |-> $onehot(c.ladder_top_node))
    else $error("ladder source not one-hot");
  ref_pin_off_a: assert property (
    c.ladder_top_node[0] |-> !c.vref_pin_connect)
    else $error("reference pin joined on supply source");
  supply_unity_a: assert property (
    c.ladder_top_node[0] |-> !c.gain_x2)
    else $error("gain two on supply source");
  gain2_src_a: assert property (
    c.gain_x2 |-> |c.ladder_top_node[3:1])
    else $error("gain two without pin or bandgap");
  doubler_a: assert property (
    c.bandgap_doubler_en == (c.ladder_top_node[1] && c.ladder_connect))
    else $error("doubler enable wrong");
  pd_hiz_a: assert property (
    !c.amp_en |-> !c.analog_output_pin_oe && c.analog_output_pin_mv == '0)
    else $error("output driven while amplifier off");
  pd_ladder_a: assert property (
    !c.amp_en |-> !c.ladder_connect && !c.vref_pin_connect)
    else $error("ladder connected in power-down");
  analog_output_pin_sat_a: assert property (
    $stable(vdd_mv_in) |-> c.analog_output_pin_mv <= vdd_mv_in)
    else $error("output above supply");
  apb_ready_a: assert property (
    psel_in && !penable_in |=> pready_out && penable_in)
    else $error("no ready in first access cycle");
  cover property (c.gain_x2 && c.ladder_top_node[1]);
  cover property (!c.amp_en ##1 c.amp_en);
  cover property ($changed(c.code));
endmodule

// ---- bench/dac_reference_gain_output_control_tb_top.sv ----
module dac_reference_gain_output_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic        brown_out_in = 1'b0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic [15:0] vdd_mv_in = 16'h1388;
  logic [15:0] vref_mv_in = 16'h07d0;
  logic [31:0] prdata_out;
  logic [31:0] rd;
  logic        pready_out;
  logic        pslverr_out;
  logic        scl_in;
  logic        er;
  int          n_fail = 0;
  int          checked = 0;
  int          cycles = 0;
  dac_ctrl_pkg::chan_out_t [1:0] chan_out;
  always #5 core_clk_in = ~core_clk_in;
  dac_reference_gain_output_control i_dut (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .brown_out_in(brown_out_in), .scl_in(scl_in), .vdd_mv_in(vdd_mv_in),
    .vref_mv_in(vref_mv_in), .chan_out(chan_out));
  host_serial_model i_host (.core_clk_in(core_clk_in), .scl_out(scl_in));
  task automatic finish_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    r = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge core_clk_in);
  endtask
  function automatic logic [31:0] exp_analog_output_pin(logic [1:0] r, logic g,
                                           logic [11:0] cd);
    logic [31:0] top;
    logic [31:0] v;
    top = (r == 2'h0) ? 32'(vdd_mv_in) : (r == 2'h1) ?
          32'(dac_ctrl_pkg::BANDGAP_MV) * 2 : 32'(vref_mv_in);
    v = (top * 32'(cd)) >> 12;
    if (g && r != 2'h0) v = v * 2;
    return (v > 32'(vdd_mv_in)) ? 32'(vdd_mv_in) : v;
  endfunction
  task automatic chk_chan(input int ch, input logic [1:0] r, input logic g,
                          input logic [11:0] cd);
    dac_ctrl_pkg::chan_out_t o;
    o = chan_out[ch];
    chk("top", 32'(4'h1 << r), 32'(o.ladder_top_node));
    chk("gain2", 32'(g && r != 2'h0), 32'(o.gain_x2));
    chk("pin", 32'(r[1]), 32'(o.vref_pin_connect));
    chk("dbl", 32'(r == 2'h1), 32'(o.bandgap_doubler_en));
    chk("code", 32'(cd), 32'(o.code));
    chk("analog_output_pin", exp_analog_output_pin(r, g, cd), 32'(o.analog_output_pin_mv));
  endtask
  task automatic t_sources();
    apb(1'b1, 8'h00, 32'hfff, rd, er);
    apb(1'b1, 8'h04, 32'hfff, rd, er);
    i_host.ack_pulse();
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 8'h08, 32'(i[1:0] * 5), rd, er);
      apb(1'b1, 8'h10, i[2] ? 32'h300 : 32'h0, rd, er);
      tick(2);
      chk_chan(0, i[1:0], i[2], 12'hfff);
      chk_chan(1, i[1:0], i[2], 12'hfff);
    end
  endtask
  task automatic t_commit();
    apb(1'b1, 8'h00, 32'h123, rd, er);
    tick(2);
    chk("held", 32'hfff, 32'(chan_out[0].code));
    apb(1'b0, 8'h3c, 32'h0, rd, er);
    chk("pend", 32'h1, rd & 32'h3);
    i_host.ack_pulse();
    tick(4);
    chk("commit", 32'h123, 32'(chan_out[0].code));
  endtask
  task automatic t_sat();
    vref_mv_in <= vdd_mv_in;
    apb(1'b1, 8'h08, 32'h2, rd, er);
    apb(1'b1, 8'h10, 32'h100, rd, er);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, 8'h00, k ? 32'hfff : 32'h800, rd, er);
      i_host.ack_pulse();
      tick(4);
      chk_chan(0, 2'h2, 1'b1, k ? 12'hfff : 12'h800);
    end
    // pin tied to supply: host programs the supply code instead
    apb(1'b1, 8'h08, 32'h0, rd, er);
    tick(2);
    chk_chan(0, 2'h0, 1'b1, 12'hfff);
    vref_mv_in <= 16'h07d0;
  endtask
  task automatic t_pd();
    for (int m = 1; m < 4; m++) begin
      apb(1'b1, 8'h0c, 32'(m), rd, er);
      tick(2);
      chk("oe", 32'h0, 32'(chan_out[0].analog_output_pin_oe));
      chk("amp", 32'h0, 32'(chan_out[0].amp_en));
      chk("ladder", 32'h0, 32'(chan_out[0].ladder_connect));
    end
    apb(1'b1, 8'h0c, 32'h0, rd, er);
  endtask
  task automatic t_reload();
    apb(1'b1, 8'h20, 32'h0aa, rd, er);
    apb(1'b1, 8'h28, 32'h1, rd, er);
    apb(1'b1, 8'h30, 32'h100, rd, er);
    apb(1'b1, 8'h38, 32'h1, rd, er);
    tick(2);
    chk_chan(0, 2'h1, 1'b1, 12'h0aa);
    apb(1'b1, 8'h08, 32'h0, rd, er);
    apb(1'b1, 8'h10, 32'h0, rd, er);
    brown_out_in <= 1'b1;
    tick(2);
    brown_out_in <= 1'b0;
    tick(8);
    chk_chan(0, 2'h1, 1'b1, 12'h0aa);
  endtask
  initial begin
    repeat (4) @(posedge core_clk_in);
    srst_in <= 1'b0;
    tick(3);
    chk_chan(0, 2'h0, 1'b0, 12'h7ff);
    t_sources();
    t_commit();
    t_sat();
    t_pd();
    t_reload();
    // unmapped word answers with an error and reads zero
    apb(1'b0, 8'h40, 32'h0, rd, er);
    chk("err", 32'h1, 32'(er));
    chk("rdata", 32'h0, rd);
    finish_test();
  end
endmodule
bind dac_reference_gain_output_control dac_ctrl_checker i_chk (
  .core_clk_in(core_clk_in), .srst_in(srst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pready_out(pready_out),
  .vdd_mv_in(vdd_mv_in), .chan_out(chan_out));

// ---- bench/host_serial_model.sv ----
module host_serial_model (
  input  wire logic core_clk_in,
  output logic      scl_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // line idles high through its pull-up; clock stands still between frames
  initial scl_out = 1'b1;
  task automatic ack_pulse();
    scl_out <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    scl_out <= 1'b1;
    repeat (2) @(posedge core_clk_in);
  endtask
endmodule

// ---- verilog/dac_ctrl_pkg.sv ----
package dac_ctrl_pkg;
  localparam int CHANNELS  = 2;
  localparam int CODE_BITS = 12;
  localparam int LADDER    = 4096;
  localparam int MV_BITS   = 16;

  // apb register byte offsets
  localparam logic [7:0] DAC0_VOL_OFS  = 8'h00;
  localparam logic [7:0] REF_VOL_OFS   = 8'h08;
  localparam logic [7:0] PD_VOL_OFS    = 8'h0c;
  localparam logic [7:0] GAIN_VOL_OFS  = 8'h10;
  localparam logic [7:0] DAC0_NV_OFS   = 8'h20;
  localparam logic [7:0] REF_NV_OFS    = 8'h28;
  localparam logic [7:0] PD_NV_OFS     = 8'h2c;
  localparam logic [7:0] GAIN_NV_OFS   = 8'h30;
  localparam logic [7:0] CMD_OFS       = 8'h38;
  localparam logic [7:0] STATUS_OFS    = 8'h3c;
  localparam logic [7:0] CH_STRIDE     = 8'h04;

  // field positions
  localparam int GAIN0_POS   = 8;
  localparam int CMD_GCR_POS = 0;
  localparam int ST_PEND_POS = 0;
  localparam int ST_GX2_POS  = 2;
  localparam int ST_SCL_POS  = 4;
  localparam int ST_BOR_POS  = 5;

  // values after reset (nonvolatile defaults)
  localparam logic [CODE_BITS-1:0] CODE_RST = 12'h7ff;
  localparam logic [1:0]           REF_RST  = 2'h0;
  localparam logic [1:0]           PD_RST   = 2'h0;
  localparam logic                 GAIN_RST = 1'b0;

  localparam logic [MV_BITS-1:0] BANDGAP_MV = 16'h04c4;

  typedef enum logic [1:0] {
    REF_SUPPLY   = 2'h0,
    REF_BANDGAP  = 2'h1,
    REF_PIN      = 2'h2,
    REF_PIN_BUF  = 2'h3
  } ref_source_select_t;

  typedef struct packed {
    logic [3:0]           ladder_top_node;
    logic                 ladder_connect;
    logic                 vref_pin_connect;
    logic                 bandgap_doubler_en;
    logic                 gain_x2;
    logic                 amp_en;
    logic                 analog_output_pin_oe;
    logic [CODE_BITS-1:0] code;
    logic [MV_BITS-1:0]   analog_output_pin_mv;
  } chan_out_t;
endpackage

// ---- verilog/dac_reference_gain_output_control.sv ----
// Functional notes
// - four ladder sources picked by two-bit select
// - volatile select active; reset reloads from nonvolatile
// - supply source keeps reference pin disconnected
// - gain bit 0 gives 1, 1 gives 2
// - supply reference ignores gain bit, unity gain
// - gain two only for pin or bandgap
// - bandgap source passes through doubling buffer
// - power-down disables amplifier, output high impedance
// - volatile gain changes only on four events
// - output equals top voltage times code/ladder times gain
// - ladder of 4096 steps sets 12-bit code width
// - gain two output saturates at supply
// - reset and brown-out update the dac code
// - serial write applies code at ack falling edge
// - general call reset reloads code from nonvolatile
// - gain bits at bit 8 and 9
// - reference select 00 forces unity gain
// - powered-down channel ladder disconnected from reference
module dac_reference_gain_output_control (
  input  wire logic                                core_clk_in,
  input  wire logic                                srst_in,
  input  wire logic                                psel_in,
  input  wire logic                                penable_in,
  input  wire logic                                pwrite_in,
  input  wire logic [7:0]                          paddr_in,
  input  wire logic [31:0]                         pwdata_in,
  output logic      [31:0]                         prdata_out,
  output logic                                     pready_out,
  output logic                                     pslverr_out,
  input  wire logic                                brown_out_in,
  input  wire logic                                scl_in,
  input  wire logic [dac_ctrl_pkg::MV_BITS-1:0]    vdd_mv_in,
  input  wire logic [dac_ctrl_pkg::MV_BITS-1:0]    vref_mv_in,
  output dac_ctrl_pkg::chan_out_t [dac_ctrl_pkg::CHANNELS-1:0] chan_out
);
  localparam int NCH = dac_ctrl_pkg::CHANNELS;
  localparam int CB  = dac_ctrl_pkg::CODE_BITS;
  localparam int MB  = dac_ctrl_pkg::MV_BITS;

  logic [CB-1:0]  code_vol  [NCH];
  logic [CB-1:0]  code_nv   [NCH];
  logic [CB-1:0]  code_stage[NCH];
  logic [NCH-1:0] pending;
  logic [1:0]     ref_vol   [NCH];
  logic [1:0]     ref_nv    [NCH];
  logic [1:0]     pd_vol    [NCH];
  logic [1:0]     pd_nv     [NCH];
  logic [NCH-1:0] gain_vol;
  logic [NCH-1:0] gain_nv;
  logic [NCH-1:0] eff_x2;

  // apb access phase completes on the edge that sees pready high
  logic wr_done;
  logic rd_setup;
  assign wr_done  = psel_in & penable_in & pready_out & pwrite_in;
  assign rd_setup = psel_in & ~penable_in;

  // pin synchronisers: a change counts once stages 2 and 3 agree
  logic [2:0] scl_sync;
  logic [2:0] bor_sync;
  logic       scl_lvl;
  logic       bor_lvl;
  logic       ack_fall;
  logic       bor_rise;

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      scl_sync <= 3'h7;
      bor_sync <= 3'h0;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_in};
      bor_sync <= {bor_sync[1:0], brown_out_in};
    end
  end

  assign ack_fall = scl_lvl & (scl_sync[1] == scl_sync[2]) & ~scl_sync[2];
  assign bor_rise = ~bor_lvl & (bor_sync[1] == bor_sync[2]) & bor_sync[2];

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      scl_lvl <= 1'b1;
      bor_lvl <= 1'b0;
    end else begin
      if (scl_sync[1] == scl_sync[2]) begin
        scl_lvl <= scl_sync[2];
      end
      if (bor_sync[1] == bor_sync[2]) begin
        bor_lvl <= bor_sync[2];
      end
    end
  end

  // general call reset arrives as a command register strobe
  logic gc_reset;
  assign gc_reset = wr_done && paddr_in == dac_ctrl_pkg::CMD_OFS
                    && pwdata_in[dac_ctrl_pkg::CMD_GCR_POS];

  logic reload;
  assign reload = bor_rise | gc_reset;

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_ch
      localparam logic [7:0] STEP = 8'(ch) * dac_ctrl_pkg::CH_STRIDE;
      logic wr_code;
      logic wr_code_nv;
      assign wr_code    = wr_done
                          && paddr_in == dac_ctrl_pkg::DAC0_VOL_OFS + STEP;
      assign wr_code_nv = wr_done
                          && paddr_in == dac_ctrl_pkg::DAC0_NV_OFS + STEP;

      // nonvolatile copies; storage timing is abstracted to one write
      always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
          code_nv[ch] <= dac_ctrl_pkg::CODE_RST;
          ref_nv[ch]  <= dac_ctrl_pkg::REF_RST;
          pd_nv[ch]   <= dac_ctrl_pkg::PD_RST;
          gain_nv[ch] <= dac_ctrl_pkg::GAIN_RST;
        end else if (wr_done) begin
          if (wr_code_nv) begin
            code_nv[ch] <= pwdata_in[CB-1:0];
          end
          if (paddr_in == dac_ctrl_pkg::REF_NV_OFS) begin
            ref_nv[ch] <= pwdata_in[2*ch +: 2];
          end
          if (paddr_in == dac_ctrl_pkg::PD_NV_OFS) begin
            pd_nv[ch] <= pwdata_in[2*ch +: 2];
          end
          if (paddr_in == dac_ctrl_pkg::GAIN_NV_OFS) begin
            gain_nv[ch] <= pwdata_in[dac_ctrl_pkg::GAIN0_POS + ch];
          end
        end
      end

      // a serial write only stages the code; it lands on the ack edge
      always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
          code_stage[ch] <= dac_ctrl_pkg::CODE_RST;
          pending[ch]    <= 1'b0;
        end else if (reload) begin
          pending[ch] <= 1'b0;
        end else if (wr_code) begin
          code_stage[ch] <= pwdata_in[CB-1:0];
          pending[ch]    <= 1'b1;
        end else if (ack_fall) begin
          pending[ch] <= 1'b0;
        end
      end

      // the power-on values equal the nonvolatile defaults
      always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
          code_vol[ch] <= dac_ctrl_pkg::CODE_RST;
        end else if (reload) begin
          code_vol[ch] <= code_nv[ch];
        end else if (pending[ch] && ack_fall) begin
          code_vol[ch] <= code_stage[ch];
        end
      end

      always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
          ref_vol[ch]  <= dac_ctrl_pkg::REF_RST;
          pd_vol[ch]   <= dac_ctrl_pkg::PD_RST;
          gain_vol[ch] <= dac_ctrl_pkg::GAIN_RST;
        end else if (reload) begin
          ref_vol[ch]  <= ref_nv[ch];
          pd_vol[ch]   <= pd_nv[ch];
          gain_vol[ch] <= gain_nv[ch];
        end else if (wr_done) begin
          if (paddr_in == dac_ctrl_pkg::REF_VOL_OFS) begin
            ref_vol[ch] <= pwdata_in[2*ch +: 2];
          end
          if (paddr_in == dac_ctrl_pkg::PD_VOL_OFS) begin
            pd_vol[ch] <= pwdata_in[2*ch +: 2];
          end
          if (paddr_in == dac_ctrl_pkg::GAIN_VOL_OFS) begin
            gain_vol[ch] <= pwdata_in[dac_ctrl_pkg::GAIN0_POS + ch];
          end
        end
      end

      // output stage derived from the volatile settings
      logic          down;
      logic [MB-1:0] vtop;
      logic [MB+CB-1:0] prod;
      logic [MB:0]   scaled;
      logic [MB:0]   vlim;
      assign down = pd_vol[ch] != dac_ctrl_pkg::PD_RST;
      assign eff_x2[ch] = gain_vol[ch]
                          && ref_vol[ch] != 2'(dac_ctrl_pkg::REF_SUPPLY);

      always_comb begin
        unique case (dac_ctrl_pkg::ref_source_select_t'(ref_vol[ch]))
          dac_ctrl_pkg::REF_SUPPLY:  vtop = vdd_mv_in;
          dac_ctrl_pkg::REF_BANDGAP:
            vtop = MB'({dac_ctrl_pkg::BANDGAP_MV, 1'b0});
          dac_ctrl_pkg::REF_PIN:     vtop = vref_mv_in;
          dac_ctrl_pkg::REF_PIN_BUF: vtop = vref_mv_in;
        endcase
      end

      // ladder count is 2**CB, so the divide is a shift
      assign prod   = vtop * code_vol[ch];
      assign scaled = eff_x2[ch] ? {prod[MB+CB-1:CB], 1'b0}
                                 : {1'b0, prod[MB+CB-1:CB]};
      assign vlim   = (scaled > {1'b0, vdd_mv_in}) ? {1'b0, vdd_mv_in}
                                                   : scaled;

      always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
          chan_out[ch] <= '0;
        end else begin
          chan_out[ch].ladder_top_node <= 4'h1 << ref_vol[ch];
          chan_out[ch].ladder_connect  <= ~down;
          chan_out[ch].vref_pin_connect <= ~down
              && ref_vol[ch][1];
          chan_out[ch].bandgap_doubler_en <= ~down
              && ref_vol[ch] == 2'(dac_ctrl_pkg::REF_BANDGAP);
          chan_out[ch].gain_x2 <= eff_x2[ch];
          chan_out[ch].amp_en  <= ~down;
          chan_out[ch].analog_output_pin_oe <= ~down;
          chan_out[ch].code    <= code_vol[ch];
          chan_out[ch].analog_output_pin_mv <= down ? '0 : vlim[MB-1:0];
        end
      end
    end
  endgenerate

  // read mux, loaded in the setup phase so it is valid in access
  logic [31:0] rdata;
  logic        hit;
  always_comb begin
    rdata = '0;
    hit   = 1'b1;
    unique case (paddr_in)
      dac_ctrl_pkg::DAC0_VOL_OFS:
        rdata[CB-1:0] = code_vol[0];
      dac_ctrl_pkg::DAC0_VOL_OFS + dac_ctrl_pkg::CH_STRIDE:
        rdata[CB-1:0] = code_vol[1];
      dac_ctrl_pkg::DAC0_NV_OFS:
        rdata[CB-1:0] = code_nv[0];
      dac_ctrl_pkg::DAC0_NV_OFS + dac_ctrl_pkg::CH_STRIDE:
        rdata[CB-1:0] = code_nv[1];
      dac_ctrl_pkg::REF_VOL_OFS:  rdata[3:0] = {ref_vol[1], ref_vol[0]};
      dac_ctrl_pkg::REF_NV_OFS:   rdata[3:0] = {ref_nv[1], ref_nv[0]};
      dac_ctrl_pkg::PD_VOL_OFS:   rdata[3:0] = {pd_vol[1], pd_vol[0]};
      dac_ctrl_pkg::PD_NV_OFS:    rdata[3:0] = {pd_nv[1], pd_nv[0]};
      dac_ctrl_pkg::GAIN_VOL_OFS:
        rdata[dac_ctrl_pkg::GAIN0_POS +: NCH] = gain_vol;
      dac_ctrl_pkg::GAIN_NV_OFS:
        rdata[dac_ctrl_pkg::GAIN0_POS +: NCH] = gain_nv;
      dac_ctrl_pkg::CMD_OFS:      rdata = '0;
      dac_ctrl_pkg::STATUS_OFS: begin
        rdata[dac_ctrl_pkg::ST_PEND_POS +: NCH] = pending;
        rdata[dac_ctrl_pkg::ST_GX2_POS +: NCH]  = eff_x2;
        rdata[dac_ctrl_pkg::ST_SCL_POS]         = scl_lvl;
        rdata[dac_ctrl_pkg::ST_BOR_POS]         = bor_lvl;
      end
      default:                    hit = 1'b0;
    endcase
  end

  // one wait-free access cycle; unmapped addresses answer with an error
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= '0;
    end else begin
      pready_out  <= rd_setup;
      pslverr_out <= rd_setup & ~hit;
      if (rd_setup && !pwrite_in) begin
        prdata_out <= rdata;
      end
    end
  end
endmodule
